// ==== logic/mcgen_pkg.sv ====
/*
 * Constants for the microcontroller clock output generator.
 * Assumes a 250 MHz core clock standing in for the crystal domain.
 */
package mcgen_pkg;
    localparam logic [7:0] MCGEN_CLKOUT_ADDR  = 8'h0a;
    localparam logic [7:0] MCGEN_CLKOUT_RESET = 8'h06;
    localparam int         MCGEN_TAIL_LSB     = 4;
    localparam int         MCGEN_LFEN_BIT     = 3;
    localparam int         MCGEN_DIV_LSB      = 0;
    localparam int         MCGEN_CORE_MHZ     = 250;
    localparam int         MCGEN_XTAL_KHZ     = 30000;
    localparam int         MCGEN_SWRST_MIN_US = 50;
    localparam int         MCGEN_SWRST_MAX_US = 470;
    // Pick a pulse near the short end of the range, rounded to whole cycles
    localparam int         MCGEN_SWRST_US     = 100;
    localparam int         MCGEN_SWRST_CYC    = MCGEN_SWRST_US * MCGEN_CORE_MHZ;
    localparam logic [9:0] MCGEN_TAIL_128     = 10'h080;
    localparam logic [9:0] MCGEN_TAIL_256     = 10'h100;
    localparam logic [9:0] MCGEN_TAIL_512     = 10'h200;

    typedef enum logic [1:0] {
        MCGEN_RUN  = 2'b00,
        MCGEN_TAIL = 2'b01,
        MCGEN_OFF  = 2'b10,
        MCGEN_LOW  = 2'b11
    } mcgen_state_type;
endpackage : mcgen_pkg

// ==== logic/mcgen_top.sv ====
/*
 * Microcontroller clock output generator: register 0Ah, divider, sleep
 * handling, clock tail, software reset pulse and reset pins.
 * Assumes i_xtal_tick pulses at twice the crystal rate, one core cycle wide,
 * and i_rc_tick or i_x32_tick twice per low-frequency period.
 */
`timescale 1ns/1ps
`default_nettype none
module mcgen_top
    import mcgen_pkg::*;
#(
    parameter int SWRST_CYCLES = MCGEN_SWRST_CYC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    input  wire logic       i_xtal_tick,
    input  wire logic       i_rc_tick,
    input  wire logic       i_x32_tick,
    input  wire logic       i_x32_sel,
    input  wire logic       i_sleep_req,
    input  wire logic       i_irq_pending,
    input  wire logic       i_soft_reset,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic            o_aux_pin_three,
    output logic            o_aux_pin_zero,
    output logic            o_aux_pin_one,
    output logic            o_xtal_en,
    output logic            o_int_reset
);
    import mcgen_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // Counter is 20 bits wide; the window bound keeps it from wrapping
    if (SWRST_CYCLES < MCGEN_SWRST_MIN_US * MCGEN_CORE_MHZ ||
        SWRST_CYCLES > MCGEN_SWRST_MAX_US * MCGEN_CORE_MHZ) begin : g_bad_swrst
        $error("soft reset pulse length out of range");
    end

    // ------------------------------------------------------------
    // Software reset pulse
    // ------------------------------------------------------------
    logic [19:0] swrst_cnt_r;
    logic        rst_act;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            swrst_cnt_r <= 20'h00000;
        end else if (i_ce) begin
            if (i_soft_reset) begin
                swrst_cnt_r <= 20'(SWRST_CYCLES);
            end else if (swrst_cnt_r != 20'h00000) begin
                swrst_cnt_r <= swrst_cnt_r - 20'h00001;
            end
        end
    end

    assign rst_act = (swrst_cnt_r != 20'h00000);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_int_reset <= 1'b1;
        end else if (i_ce) begin
            o_int_reset <= rst_act;
        end
    end

    // Pins to the microcontroller; both flops share one edge, never skewed
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_aux_pin_zero <= 1'b1;
            o_aux_pin_one  <= 1'b0;
        end else if (i_ce) begin
            o_aux_pin_zero <= rst_act;
            o_aux_pin_one  <= !rst_act;
        end
    end

    // ------------------------------------------------------------
    // Clock-output register
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [1:0] tail_sel;
    logic       lf_en;
    logic [2:0] div_sel;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_r <= MCGEN_CLKOUT_RESET;
        end else if (i_ce) begin
            if (rst_act) begin
                ctrl_r <= MCGEN_CLKOUT_RESET;
            end else if (i_wr_en && i_addr == MCGEN_CLKOUT_ADDR) begin
                ctrl_r <= {2'b00, i_wdata[5:0]};
            end
        end
    end

    assign tail_sel = ctrl_r[MCGEN_TAIL_LSB +: 2];
    assign lf_en    = ctrl_r[MCGEN_LFEN_BIT];
    assign div_sel  = ctrl_r[MCGEN_DIV_LSB +: 3];

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_rd_en && i_addr == MCGEN_CLKOUT_ADDR) begin
                o_rdata <= ctrl_r;
            end else if (i_rd_en) begin
                // Only one register here; other addresses read as zero
                o_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Divided and low-frequency clocks
    // ------------------------------------------------------------
    logic [4:0] half_div;
    logic [4:0] div_cnt_r;
    logic       div_clk_r;
    logic       lf_tick;
    logic       lf_clk_r;
    logic       lf_only;

    assign lf_tick = i_x32_sel ? i_x32_tick : i_rc_tick;
    assign lf_only = (div_sel == 3'h7);

    // Ticks per output phase minus one; ticks run at twice the crystal
    // rate, so 30 MHz toggles on every tick and bypasses the counter
    always_comb begin
        case (div_sel)
            3'h1: begin
                half_div = 5'h01;
            end
            3'h2: begin
                half_div = 5'h02;
            end
            3'h3: begin
                half_div = 5'h07;
            end
            3'h4: begin
                half_div = 5'h09;
            end
            3'h5: begin
                half_div = 5'h0e;
            end
            3'h6: begin
                half_div = 5'h1d;
            end
            default: begin
                half_div = 5'h00;
            end
        endcase
    end

    // 4 MHz needs 15 ticks a period: high 7, low 8, every edge on a tick
    logic [4:0] half_now;
    always_comb begin
        half_now = half_div;
        if (div_sel == 3'h3 && div_clk_r) begin
            half_now = 5'h06;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_cnt_r <= 5'h00;
            div_clk_r <= 1'b0;
        end else if (i_ce && i_xtal_tick && o_xtal_en) begin
            if (div_sel == 3'h0) begin
                div_clk_r <= !div_clk_r;
                div_cnt_r <= 5'h00;
            end else if (div_cnt_r >= half_now) begin
                div_clk_r <= !div_clk_r;
                div_cnt_r <= 5'h00;
            end else begin
                div_cnt_r <= div_cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lf_clk_r <= 1'b0;
        end else if (i_ce && lf_tick) begin
            lf_clk_r <= !lf_clk_r;
        end
    end

    // ------------------------------------------------------------
    // Sleep sequencing and tail
    // ------------------------------------------------------------
    mcgen_state_type state_r;
    logic [9:0]      tail_cnt_r;
    logic [9:0]      tail_len;
    logic            go_sleep;
    logic            div_fall;
    logic            div_prev_r;

    // Pending interrupt holds the chip awake until software reads it
    assign go_sleep = i_sleep_req && !i_irq_pending;

    always_comb begin
        case (tail_sel)
            2'h1: begin
                tail_len = MCGEN_TAIL_128;
            end
            2'h2: begin
                tail_len = MCGEN_TAIL_256;
            end
            2'h3: begin
                tail_len = MCGEN_TAIL_512;
            end
            default: begin
                tail_len = 10'h000;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_prev_r <= 1'b0;
        end else if (i_ce) begin
            div_prev_r <= div_clk_r;
        end
    end

    assign div_fall = div_prev_r && !div_clk_r;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r    <= MCGEN_RUN;
            tail_cnt_r <= 10'h000;
        end else if (i_ce) begin
            case (state_r)
                MCGEN_RUN: begin
                    if (go_sleep && lf_en) begin
                        state_r <= MCGEN_LOW;
                    end else if (go_sleep) begin
                        tail_cnt_r <= tail_len;
                        state_r    <= MCGEN_TAIL;
                    end
                end
                MCGEN_TAIL: begin
                    if (!go_sleep) begin
                        state_r <= MCGEN_RUN;
                    end else if (tail_cnt_r == 10'h000) begin
                        state_r <= MCGEN_OFF;
                    end else if (lf_only ? (lf_tick && lf_clk_r) : div_fall) begin
                        tail_cnt_r <= tail_cnt_r - 10'h001;
                    end
                end
                MCGEN_OFF: begin
                    if (!go_sleep) begin
                        state_r <= MCGEN_RUN;
                    end
                end
                MCGEN_LOW: begin
                    if (!go_sleep) begin
                        state_r <= MCGEN_RUN;
                    end
                end
                default: begin
                    state_r <= MCGEN_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Glitch-free output selection
    // ------------------------------------------------------------
    logic want_lf;
    logic want_on;
    logic use_lf_r;
    logic gate_on_r;
    logic cur_src;

    assign want_lf = lf_only || (state_r == MCGEN_LOW);
    assign want_on = (state_r != MCGEN_OFF);
    assign cur_src = use_lf_r ? lf_clk_r : div_clk_r;

    // Source and gate change only while the output sits low
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            use_lf_r  <= 1'b0;
            gate_on_r <= 1'b1;
        end else if (i_ce) begin
            if (!o_aux_pin_three && !cur_src) begin
                gate_on_r <= want_on;
                if (use_lf_r != want_lf) begin
                    // Target must also be low before taking it
                    if (!(want_lf ? lf_clk_r : div_clk_r)) begin
                        use_lf_r <= want_lf;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_aux_pin_three <= 1'b0;
        end else if (i_ce) begin
            o_aux_pin_three <= gate_on_r && cur_src;
        end
    end

    // ------------------------------------------------------------
    // Crystal enable
    // ------------------------------------------------------------
    // Crystal stays on through the tail so counted cycles are real, and
    // until the output has left the divided clock: a divider frozen high
    // would hold the pin high and block the handover for good
    always_comb begin
        o_xtal_en = 1'b1;
        case (state_r)
            MCGEN_RUN: begin
                o_xtal_en = 1'b1;
            end
            MCGEN_TAIL: begin
                o_xtal_en = 1'b1;
            end
            MCGEN_OFF: begin
                o_xtal_en = gate_on_r;
            end
            MCGEN_LOW: begin
                o_xtal_en = !use_lf_r;
            end
            default: begin
                o_xtal_en = 1'b1;
            end
        endcase
    end
endmodule : mcgen_top
`default_nettype wire

// ==== logic/unused_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/mcgen_checker.sv ====
/* Port checker for mcgen_top, bound to every instance.
   Assumes i_ce is held high while the block is checked. */
`timescale 1ns/1ps
`default_nettype none
module mcgen_checker
    import mcgen_pkg::*;
#(
    parameter int SWRST_CYCLES = MCGEN_SWRST_CYC
) (
    input wire logic       i_core_clk,
    input wire logic       i_nrst,
    input wire logic       i_ce,
    input wire logic       i_xtal_tick,
    input wire logic       i_rc_tick,
    input wire logic       i_x32_tick,
    input wire logic       i_x32_sel,
    input wire logic       i_sleep_req,
    input wire logic       i_irq_pending,
    input wire logic       i_soft_reset,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       o_aux_pin_three,
    input wire logic       o_aux_pin_zero,
    input wire logic       o_aux_pin_one,
    input wire logic       o_xtal_en,
    input wire logic       o_int_reset
);
    // ----------------
    // Helper mirrors
    // ----------------
    logic [7:0] reg_r;
    int         cnt_r;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) reg_r <= MCGEN_CLKOUT_RESET;
        else if (o_int_reset) reg_r <= MCGEN_CLKOUT_RESET;
        else if (i_wr_en && i_addr == MCGEN_CLKOUT_ADDR) reg_r <= {2'b00, i_wdata[5:0]};
    end
    // Minus one keeps the power-up release out of the pulse count
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) cnt_r <= -1;
        else if (i_soft_reset) cnt_r <= 0;
        else if (o_int_reset && cnt_r >= 0) cnt_r <= cnt_r + 1;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_reset_pins_inv: assert property (o_aux_pin_one == !o_aux_pin_zero)
        else $error("aux pins not complementary");
    a_reset_pin_follow: assert property (o_aux_pin_zero == o_int_reset)
        else $error("reset pin differs from internal reset");
    a_soft_reset_len: assert property ($fell(o_int_reset) && cnt_r >= 0 |->
        cnt_r == SWRST_CYCLES) else $error("soft reset pulse length wrong");
    a_sleep_xtal_off: assert property (!o_xtal_en |->
        $past(i_sleep_req && !i_irq_pending)) else $error("crystal off without sleep");
    a_irq_keeps_xtal: assert property (i_irq_pending |=> o_xtal_en)
        else $error("crystal off with interrupt pending");
    a_awake_xtal_on: assert property (!i_sleep_req |=> o_xtal_en)
        else $error("crystal off while awake");
    a_gated_pin_low: assert property (!reg_r[3] && !o_xtal_en && !o_aux_pin_three
        && i_sleep_req && !i_irq_pending |=> !o_aux_pin_three)
        else $error("gated clock pin rose");
    a_read_ctrl_val: assert property (i_rd_en && i_addr == MCGEN_CLKOUT_ADDR |=>
        o_rdata == $past(reg_r)) else $error("control register read wrong");
    a_unmapped_zero: assert property (i_rd_en && i_addr != MCGEN_CLKOUT_ADDR |=>
        o_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_stands: assert property (!i_rd_en |=> $stable(o_rdata))
        else $error("read data changed without read");
endmodule : mcgen_checker
bind mcgen_top mcgen_checker #(.SWRST_CYCLES(SWRST_CYCLES)) u_checker (.*);
`default_nettype wire

// ==== verification/mcgen_mcu_model.sv ====
/* Microcontroller model clocked from the clock pin.
   Assumes the core clock samples the pin; it reads an interrupt after
   four of its own clock rises, so a stopped clock never clears it. */
`timescale 1ns/1ps
`default_nettype none
module mcgen_mcu_model (
    input  wire logic i_core_clk,
    input  wire logic i_mcu_clk,
    input  wire logic i_irq_raise,
    output bit        o_irq_pending,
    output int        o_rises,
    output int        o_period
);
    bit prev_r;
    int now_r;
    int last_r;
    int irq_at_r;
    always @(posedge i_core_clk) begin
        prev_r <= i_mcu_clk;
        now_r  <= now_r + 1;
        if (i_mcu_clk && !prev_r) begin
            o_rises  <= o_rises + 1;
            o_period <= now_r - last_r;
            last_r   <= now_r;
        end
        if (i_irq_raise) begin
            o_irq_pending <= 1'b1;
            irq_at_r      <= o_rises;
        end else if (o_rises - irq_at_r >= 4) o_irq_pending <= 1'b0;
    end
endmodule : mcgen_mcu_model
`default_nettype wire

// ==== verification/test_mcu_clock_output_generator.sv ====
/* Self-checking bench for mcgen_top with the microcontroller model.
   Assumes crystal ticks every 2 cycles, RC every 10, 32k crystal every 14. */
`timescale 1ns/1ps
`default_nettype none
module test_mcu_clock_output_generator;
    import mcgen_pkg::*;
    localparam int SWRST = 12500;
    logic       i_core_clk = 0, i_nrst = 0, i_ce = 1, i_xtal_tick = 0, i_rc_tick = 0;
    logic       i_x32_tick = 0, i_x32_sel = 0, i_sleep_req = 0, i_soft_reset = 0;
    logic       i_wr_en = 0, i_rd_en = 0, irq_raise = 0, i_irq_pending;
    logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
    logic       o_aux_pin_three, o_aux_pin_zero, o_aux_pin_one, o_xtal_en, o_int_reset;
    int         fails = 0, checks_done = 0, rises, period, cyc = 0, reg_m = 6, r0, n;
    int         per[8] = '{4, 8, 12, 30, 40, 60, 120, 20};
    mcgen_top #(.SWRST_CYCLES(SWRST)) u_dut (.*);
    mcgen_mcu_model u_mcu (.i_core_clk, .i_mcu_clk(o_aux_pin_three), .i_irq_raise(irq_raise),
        .o_irq_pending(i_irq_pending), .o_rises(rises), .o_period(period));
    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end
    always @(negedge i_core_clk) begin
        cyc         <= cyc + 1;
        i_xtal_tick <= (cyc % 2 == 0);
        i_rc_tick   <= (cyc % 10 == 0);
        i_x32_tick  <= (cyc % 14 == 0);
    end
    task automatic check(string what, int lo, int hi, logic [31:0] got);
        checks_done++;
        if (^got === 1'bx || got < lo || got > hi) begin
            fails++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge i_core_clk);
        {i_addr, i_wdata, i_wr_en} = {a, d, 1'b1};
        @(negedge i_core_clk);
        i_wr_en = 0;
        if (a == MCGEN_CLKOUT_ADDR) reg_m = {2'b00, d[5:0]};
    endtask : wr
    task automatic rd(logic [7:0] a);
        @(negedge i_core_clk);
        {i_addr, i_rd_en} = {a, 1'b1};
        @(negedge i_core_clk);
        i_rd_en = 0;
        n = (a == MCGEN_CLKOUT_ADDR) ? reg_m : 0;
        check("rdata", n, n, o_rdata);
    endtask : rd
    // Last full period after six rises, so a source switch never spoils it
    task automatic measure(int exp);
        r0 = rises;
        for (int k = 0; k < 3000 && rises < r0 + 6; k++) @(negedge i_core_clk);
        check("period", exp, exp, period);
    endtask : measure
    task automatic wait_xtal(logic v);
        for (int k = 0; k < 3000 && o_xtal_en !== v; k++) @(negedge i_core_clk);
    endtask : wait_xtal
    initial begin
        void'($urandom(49));
        repeat (5) @(negedge i_core_clk);
        i_nrst = 1;
        rd(MCGEN_CLKOUT_ADDR);
        measure(120);
        i_ce = 0;
        repeat (2) @(negedge i_core_clk);
        r0 = rises;
        repeat (40) @(negedge i_core_clk);
        check("ce_hold", r0, r0, rises);
        i_ce = 1;
        rd(8'h0b);
        for (int d = 0; d < 8; d++) begin
            wr(MCGEN_CLKOUT_ADDR, ($urandom & 8'hf0) | d);
            rd(MCGEN_CLKOUT_ADDR);
            measure(per[d]);
        end
        for (int t = 0; t < 4; t++) begin
            wr(MCGEN_CLKOUT_ADDR, t << 4);
            r0 = rises;
            i_sleep_req = 1;
            wait_xtal(0);
            repeat (20) @(negedge i_core_clk);
            n = (t == 0) ? 0 : 64 << t;
            check("tail", n, n + 1, rises - r0);
            r0 = rises;
            repeat (50) @(negedge i_core_clk);
            check("gated", r0, r0, rises);
            check("xtal", 0, 0, o_xtal_en);
            i_sleep_req = 0;
            measure(4);
        end
        wr(MCGEN_CLKOUT_ADDR, 8'h08);
        i_sleep_req = 1;
        measure(20);
        check("xtal", 0, 0, o_xtal_en);
        i_x32_sel = 1;
        measure(28);
        {i_x32_sel, i_sleep_req} = 2'b00;
        wr(MCGEN_CLKOUT_ADDR, 8'h00);
        irq_raise = 1;
        @(negedge i_core_clk);
        {irq_raise, i_sleep_req} = 2'b01;
        repeat (2) @(negedge i_core_clk);
        check("xtal_irq", 1, 1, o_xtal_en);
        wait_xtal(0);
        check("xtal_read", 0, 0, o_xtal_en);
        i_sleep_req = 0;
        wr(MCGEN_CLKOUT_ADDR, 8'h3f);
        i_soft_reset = 1;
        @(negedge i_core_clk);
        i_soft_reset = 0;
        wr(MCGEN_CLKOUT_ADDR, 8'h11);
        reg_m = 6;
        check("int_reset", 1, 1, o_int_reset);
        check("aux_zero", 1, 1, o_aux_pin_zero);
        check("aux_one", 0, 0, o_aux_pin_one);
        for (n = 0; n < SWRST + 100 && o_int_reset === 1'b1; n++) @(negedge i_core_clk);
        check("swrst_len", SWRST - 8, SWRST - 1, n);
        rd(MCGEN_CLKOUT_ADDR);
        wr(MCGEN_CLKOUT_ADDR, 8'h2b);
        i_nrst = 0;
        repeat (2) @(negedge i_core_clk);
        i_nrst = 1;
        reg_m = 6;
        rd(MCGEN_CLKOUT_ADDR);
        end_of_test();
    end
    // Whole run needs about 20k cycles; give up at 50k
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
endmodule : test_mcu_clock_output_generator
`default_nettype wire
